// ==== inc/cod_pkg.sv ====
// Notes on behaviour
// - channels are fed from the post-divided oscillator, never the raw oscillator
// - each channel has divider, align stage, delay and source mux before output
// - every write of the calibrate trigger register starts frequency calibration
// - output delay steps of 150 ps, from 0 up to 2250 ps
// - after reset every channel stays disabled until programmed
// - clearing a channel enable bit disables that channel alone
// - global pin low or all-outputs bit zero disables every output
// - channel runs only when channel bit, global pin and global bit allow
// - divided sources and even post-divides give 50% duty cycle
// - bypassed or delayed-only duty follows odd post-divide: 33%, 40%, 43%
// - align pin low holds every divided channel low
// - bypassed channels keep toggling whatever the align pin does
// - registered align low drives divided outputs low four ticks later
// - align high releases divided outputs four ticks later
// - released divided outputs all rise on the same edge
// - align completes even if pin rises before outputs went low
// - bypassed channels stay phase-aligned since align never touches them
// - unconnected align pin reads high so outputs run normally
// - no phase alignment between channels is promised without an align event
package cod_pkg;
   localparam int COD_NUM_CH = 8;
   // register byte offsets
   localparam logic [7:0] COD_REG_CH0 = 8'h00;
   localparam logic [7:0] COD_REG_GLOBAL = 8'h20;
   localparam logic [7:0] COD_REG_CAL = 8'h24;
   localparam logic [7:0] COD_REG_STATUS = 8'h28;
   // channel register fields
   localparam int COD_DLY_LSB = 0;
   localparam int COD_DLY_W = 4;
   localparam int COD_DIV_LSB = 4;
   localparam int COD_DIV_W = 8;
   localparam int COD_EN_BIT = 12;
   localparam int COD_MUX_LSB = 13;
   localparam int COD_MUX_W = 2;
   localparam int COD_CH_W = 15;
   // global register fields
   localparam int COD_GEN_BIT = 0;
   localparam int COD_PDIV_LSB = 4;
   localparam int COD_PDIV_W = 4;
   // reset values
   localparam logic [COD_CH_W-1:0] COD_CH_RST = 15'h0010;
   localparam logic COD_GEN_RST = 1'b1;
   localparam logic [COD_PDIV_W-1:0] COD_PDIV_RST = 4'h2;
   localparam logic [COD_PDIV_W-1:0] COD_PDIV_MIN = 4'h2;
   localparam logic [COD_PDIV_W-1:0] COD_PDIV_MAX = 4'h8;
   // delay line
   localparam int COD_DELAY_STEP_PS = 150;
   localparam int COD_DELAY_MAX_PS = 2250;
   localparam int COD_DELAY_CODES = COD_DELAY_MAX_PS / COD_DELAY_STEP_PS + 1;
   // align latency in distribution-path ticks
   localparam logic [2:0] COD_ALIGN_TICKS = 3'h4;
   typedef enum logic [1:0] {
      COD_SRC_BYPASS,
      COD_SRC_DIV,
      COD_SRC_DLY,
      COD_SRC_DIV_DLY
   } cod_src_t;
   typedef enum {
      COD_AL_IDLE,
      COD_AL_LOWWAIT,
      COD_AL_HELD,
      COD_AL_HIGHWAIT
   } cod_align_t;
endpackage

// ==== rtl/cod_top.sv ====
// The register addresses and register access over APB were chosen for this implementation.
`timescale 1ns/10ps
module cod_top #(
   parameter int NUM_CH = cod_pkg::COD_NUM_CH
) (
   input wire logic clk_i,                                  // oscillator clock
   input wire logic rst_n_i,                                // sync reset, low
   input wire logic psel,                                   // apb select
   input wire logic penable,                                // apb enable
   input wire logic pwrite,                                 // apb write
   input wire logic [7:0] paddr,                            // apb byte address
   input wire logic [31:0] pwdata,                          // apb write data
   output logic [31:0] prdata,                              // apb read data
   output logic pready,                                     // apb ready
   output logic pslverr,                                    // apb error
   input wire logic global_output_enable_pin_i,             // outputs low when low
   input wire logic align_n_i,                              // align pin, low active
   output logic [NUM_CH-1:0] clkout_o,                      // channel clocks
   output logic [NUM_CH-1:0] clkout_off_o,                  // buffer off
   output logic [NUM_CH*cod_pkg::COD_DLY_W-1:0] channel_delay_code_o, // delay line codes
   output logic cal_start_o                                 // calibration start pulse
);
   import cod_pkg::*;

   logic [COD_CH_W-1:0] ch_cfg_reg [NUM_CH];
   logic all_outputs_enable_bit_reg;
   logic [COD_PDIV_W-1:0] oscillator_post_divide_reg;
   logic [31:0] prdata_reg;
   logic pready_reg;
   logic pslverr_reg;
   logic cal_start_reg;
   logic [7:0] cal_count_reg;
   logic [COD_PDIV_W-1:0] pd_cnt_reg;
   logic dist_level;
   logic dist_tick;
   cod_align_t al_state_reg;
   logic [2:0] al_cnt_reg;
   logic al_release;
   logic al_force;
   logic [NUM_CH-1:0] div_lvl_reg;
   logic [NUM_CH-1:0] clkout_reg;
   logic [NUM_CH-1:0] off_reg;
   logic [NUM_CH*COD_DLY_W-1:0] dly_reg;
   logic [NUM_CH-1:0] ch_run;
   logic [NUM_CH-1:0] ch_src;
   logic [NUM_CH*COD_DLY_W-1:0] dly_next;
   logic [COD_PDIV_W-1:0] pdiv_eff;
   logic acc_done;
   logic wr_fire;

   // byte address to channel index, or NUM_CH when not a channel register
   function automatic int ch_index(input logic [7:0] a);
      int idx;
      idx = NUM_CH;
      if (a[1:0] == 2'b00 && a >= COD_REG_CH0 && int'(a[7:2]) < NUM_CH) begin
         idx = int'(a[7:2]);
      end
      return idx;
   endfunction

   function automatic logic addr_mapped(input logic [7:0] a);
      return (ch_index(a) < NUM_CH) || a == COD_REG_GLOBAL || a == COD_REG_CAL ||
             a == COD_REG_STATUS;
   endfunction

   function automatic logic src_divided(input logic [COD_MUX_W-1:0] m);
      return m == COD_SRC_DIV || m == COD_SRC_DIV_DLY;
   endfunction

   function automatic logic src_delayed(input logic [COD_MUX_W-1:0] m);
      return m == COD_SRC_DLY || m == COD_SRC_DIV_DLY;
   endfunction

   // apb: one wait state, so an access phase lasts two cycles
   assign acc_done = psel && penable && pready_reg;
   assign wr_fire = acc_done && pwrite;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         pready_reg <= 1'b0;
      end else begin
         pready_reg <= psel && penable && !pready_reg;
      end
   end

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         prdata_reg <= 32'h0000_0000;
         pslverr_reg <= 1'b0;
      end else if (psel && penable && !pready_reg) begin
         pslverr_reg <= !addr_mapped(paddr);
         prdata_reg <= 32'h0000_0000;
         if (!pwrite) begin
            if (ch_index(paddr) < NUM_CH) begin
               prdata_reg[COD_CH_W-1:0] <= ch_cfg_reg[ch_index(paddr)];
            end else if (paddr == COD_REG_GLOBAL) begin
               prdata_reg[COD_GEN_BIT] <= all_outputs_enable_bit_reg;
               prdata_reg[COD_PDIV_LSB +: COD_PDIV_W] <= oscillator_post_divide_reg;
            end else if (paddr == COD_REG_CAL) begin
               prdata_reg[7:0] <= cal_count_reg;
            end else if (paddr == COD_REG_STATUS) begin
               prdata_reg[1:0] <= al_state_reg[1:0];
               prdata_reg[2] <= global_output_enable_pin_i;
               prdata_reg[3] <= align_n_i;
               prdata_reg[4] <= dist_level;
            end
         end
      end else begin
         pslverr_reg <= 1'b0;
      end
   end

   // channel configuration, all disabled after reset
   generate
      for (genvar g = 0; g < NUM_CH; g++) begin : g_cfg
         always_ff @(posedge clk_i) begin
            if (!rst_n_i) begin
               ch_cfg_reg[g] <= COD_CH_RST;
            end else if (wr_fire && ch_index(paddr) == g) begin
               ch_cfg_reg[g] <= pwdata[COD_CH_W-1:0];
            end
         end
      end
   endgenerate

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         all_outputs_enable_bit_reg <= COD_GEN_RST;
         oscillator_post_divide_reg <= COD_PDIV_RST;
      end else if (wr_fire && paddr == COD_REG_GLOBAL) begin
         all_outputs_enable_bit_reg <= pwdata[COD_GEN_BIT];
         oscillator_post_divide_reg <= pwdata[COD_PDIV_LSB +: COD_PDIV_W];
      end
   end

   // any write, whatever the data, restarts calibration; a valid reference is
   // software's duty at that moment
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         cal_start_reg <= 1'b0;
         cal_count_reg <= 8'h00;
      end else begin
         cal_start_reg <= wr_fire && paddr == COD_REG_CAL;
         if (wr_fire && paddr == COD_REG_CAL) begin
            cal_count_reg <= cal_count_reg + 8'h01;
         end
      end
   end

   // post-divider makes the distribution path; illegal ratios fall back to 2
   assign pdiv_eff = (oscillator_post_divide_reg < COD_PDIV_MIN ||
                      oscillator_post_divide_reg > COD_PDIV_MAX) ?
                     COD_PDIV_MIN : oscillator_post_divide_reg;

   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         pd_cnt_reg <= '0;
      end else if (pd_cnt_reg >= pdiv_eff - 4'h1) begin
         pd_cnt_reg <= '0;
      end else begin
         pd_cnt_reg <= pd_cnt_reg + 4'h1;
      end
   end

   // high for floor(n/2) of n: 50% even, 33/40/43% for 3/5/7
   assign dist_level = pd_cnt_reg < (pdiv_eff >> 1);
   assign dist_tick = pd_cnt_reg == '0;

   // align sequencer, sampled on distribution-path rising edges only
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         al_state_reg <= COD_AL_IDLE;
         al_cnt_reg <= 3'h0;
      end else if (dist_tick) begin
         unique case (al_state_reg)
            COD_AL_IDLE: begin
               al_cnt_reg <= 3'h0;
               // a floating pin reads high here, so nothing is disturbed
               if (!align_n_i) begin
                  al_state_reg <= COD_AL_LOWWAIT;
               end
            end
            COD_AL_LOWWAIT: begin
               // pin may already be high again; the low still completes
               if (al_cnt_reg == COD_ALIGN_TICKS - 3'h1) begin
                  al_state_reg <= COD_AL_HELD;
                  al_cnt_reg <= 3'h0;
               end else begin
                  al_cnt_reg <= al_cnt_reg + 3'h1;
               end
            end
            COD_AL_HELD: begin
               if (align_n_i) begin
                  al_state_reg <= COD_AL_HIGHWAIT;
               end
            end
            COD_AL_HIGHWAIT: begin
               if (al_cnt_reg == COD_ALIGN_TICKS - 3'h1) begin
                  al_state_reg <= COD_AL_IDLE;
                  al_cnt_reg <= 3'h0;
               end else begin
                  al_cnt_reg <= al_cnt_reg + 3'h1;
               end
            end
         endcase
      end
   end

   assign al_force = dist_tick && al_state_reg == COD_AL_LOWWAIT &&
                     al_cnt_reg == COD_ALIGN_TICKS - 3'h1;
   // release on the fourth tick after the high is seen, mirroring the low side
   // dividers are only in phase after this point
   assign al_release = dist_tick && al_state_reg == COD_AL_HIGHWAIT &&
                       al_cnt_reg == COD_ALIGN_TICKS - 3'h1;

   generate
      for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
         logic [COD_DIV_W-1:0] div_cnt_reg;
         logic [COD_DIV_W-1:0] div_val;
         logic [COD_MUX_W-1:0] mux;
         assign mux = ch_cfg_reg[g][COD_MUX_LSB +: COD_MUX_W];
         assign div_val = (ch_cfg_reg[g][COD_DIV_LSB +: COD_DIV_W] == '0) ? 8'h01 :
                          ch_cfg_reg[g][COD_DIV_LSB +: COD_DIV_W];

         // toggles every div_val ticks: ratio 2*div_val, always 50%
         always_ff @(posedge clk_i) begin
            if (!rst_n_i) begin
               div_cnt_reg <= '0;
               div_lvl_reg[g] <= 1'b0;
            end else if (al_force || (dist_tick && al_state_reg == COD_AL_HELD)) begin
               div_cnt_reg <= '0;
               div_lvl_reg[g] <= 1'b0;
            end else if (al_release) begin
               div_cnt_reg <= '0;
               div_lvl_reg[g] <= 1'b1;
            end else if (dist_tick && al_state_reg != COD_AL_HIGHWAIT) begin
               if (div_cnt_reg >= div_val - 8'h01) begin
                  div_cnt_reg <= '0;
                  div_lvl_reg[g] <= !div_lvl_reg[g];
               end else begin
                  div_cnt_reg <= div_cnt_reg + 8'h01;
               end
            end
         end

         // bypass follows the path directly, untouched by align
         assign ch_src[g] = src_divided(mux) ? div_lvl_reg[g] : dist_level;
         assign ch_run[g] = ch_cfg_reg[g][COD_EN_BIT] && all_outputs_enable_bit_reg &&
                            global_output_enable_pin_i;
         // code times 150 ps on the analog line; zero when not delayed
         assign dly_next[g*COD_DLY_W +: COD_DLY_W] = src_delayed(mux) ?
                ch_cfg_reg[g][COD_DLY_LSB +: COD_DLY_W] : '0;
      end
   endgenerate

   // off when a bit forbids; driven low when only the pin forbids
   always_ff @(posedge clk_i) begin
      if (!rst_n_i) begin
         clkout_reg <= '0;
         off_reg <= '1;
         dly_reg <= '0;
      end else begin
         clkout_reg <= ch_src & ch_run;
         for (int i = 0; i < NUM_CH; i++) begin
            off_reg[i] <= !(ch_cfg_reg[i][COD_EN_BIT] && all_outputs_enable_bit_reg);
         end
         dly_reg <= dly_next;
      end
   end

   assign prdata = prdata_reg;
   assign pready = pready_reg;
   assign pslverr = pslverr_reg;
   assign clkout_o = clkout_reg;
   assign clkout_off_o = off_reg;
   assign channel_delay_code_o = dly_reg;
   assign cal_start_o = cal_start_reg;

   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (!rst_n_i);

   AST_CAL_PULSE: assert property (wr_fire && paddr == COD_REG_CAL |=> cal_start_o)
      else $error("calibration not started after trigger write");
   AST_RESET_OFF: assert property ($past(!rst_n_i) |-> clkout_off_o == '1 && clkout_o == '0)
      else $error("channel active right after reset");
   AST_PIN_GATE: assert property (!global_output_enable_pin_i |=> clkout_o == '0)
      else $error("output toggles with global pin low");
   AST_BIT_GATE: assert property (!all_outputs_enable_bit_reg |=> clkout_off_o == '1)
      else $error("output on with all-outputs bit clear");
   AST_CH_OFF: assert property (!ch_cfg_reg[0][COD_EN_BIT] |=> clkout_off_o[0] && !clkout_o[0])
      else $error("channel 0 on with its enable clear");
   AST_ALIGN_FOUR: assert property (al_state_reg == COD_AL_IDLE && dist_tick && !align_n_i
      |=> al_state_reg == COD_AL_LOWWAIT && al_cnt_reg == 3'h0)
      else $error("align low not registered");
   AST_ALIGN_LOW: assert property (al_force |=> al_state_reg == COD_AL_HELD && div_lvl_reg == '0)
      else $error("divided outputs not low on fifth edge");
   AST_HELD: assert property (al_state_reg == COD_AL_HELD |-> div_lvl_reg == '0)
      else $error("divided output high while held");
   AST_RELEASE: assert property (al_release |=> div_lvl_reg == '1 ##1
      (clkout_o == (ch_run & $past(ch_src))))
      else $error("divided outputs did not rise together");
   AST_BYPASS: assert property (ch_run[0] && !src_divided(ch_cfg_reg[0][COD_MUX_LSB +: COD_MUX_W])
      |=> clkout_o[0] == $past(dist_level))
      else $error("bypass channel not following path");
   AST_LOWWAIT_LEN: assert property (al_state_reg == COD_AL_LOWWAIT |-> al_cnt_reg < COD_ALIGN_TICKS)
      else $error("align count overran");

   COV_ALIGN: cover property (al_release);
   COV_CAL: cover property (cal_start_o);
   COV_EARLY_HIGH: cover property (al_state_reg == COD_AL_LOWWAIT && align_n_i ##[1:40] al_force);
   COV_ODD_DIV: cover property (pdiv_eff == 4'h3 && ch_run[0]);
endmodule

// ==== verif/cod_clk_sink.sv ====
`timescale 1ns/10ps
module cod_clk_sink #(
   parameter int NUM_CH = 8
) (
   input wire logic clk_i,                 // oscillator clock
   input wire logic [NUM_CH-1:0] clkout_i, // received channel clocks
   input wire logic clear_i,               // restart the counts
   output int hi_cnt_o [NUM_CH],           // high samples since clear
   output int lo_max_o [NUM_CH]            // longest low run since clear
);
   int lo_run [NUM_CH];
   // a passive receiver: it only counts what arrives on each channel
   always_ff @(posedge clk_i) begin
      for (int c = 0; c < NUM_CH; c++) begin
         if (clear_i) begin
            hi_cnt_o[c] <= 0;
            lo_run[c] <= 0;
            lo_max_o[c] <= 0;
         end else if (clkout_i[c] === 1'b1) begin
            hi_cnt_o[c] <= hi_cnt_o[c] + 1;
            lo_run[c] <= 0;
         end else begin
            lo_run[c] <= lo_run[c] + 1;
            if (lo_run[c] >= lo_max_o[c]) begin
               lo_max_o[c] <= lo_run[c] + 1;
            end
         end
      end
   end
endmodule

// ==== verif/clock_output_distribution_tb_top.sv ====
`timescale 1ns/10ps
module clock_output_distribution_tb_top;
   import cod_pkg::*;
   typedef struct {
      logic [7:0] a;
      logic [31:0] d;
      logic [31:0] e;
      logic err;
   } cod_row_t;
   localparam int NCH = COD_NUM_CH;
   logic clk_i, rst_n_i, psel, penable, pwrite, pready, pslverr;
   logic gpin, align_n, cal_start, clear, err;
   logic [7:0] paddr;
   logic [31:0] pwdata, prdata, rd;
   logic [NCH-1:0] clkout, clkoff;
   logic [NCH*COD_DLY_W-1:0] dly;
   int hi [NCH];
   int lo_max [NCH];
   int n_mismatch = 0;
   int compares = 0;
   int cal_seen = 0;
   int n;
   int pd [5] = '{3, 4, 5, 7, 8};
   cod_row_t rows [5] = '{'{8'h00, 32'hffff_ffff, 32'h0000_7fff, 1'b0},
      '{8'h1c, 32'h0000_5a5a, 32'h0000_5a5a, 1'b0},
      '{8'h20, 32'hffff_fff0, 32'h0000_00f0, 1'b0},
      '{8'h40, 32'h1234_5678, 32'h0000_0000, 1'b1},
      '{8'hfc, 32'hffff_ffff, 32'h0000_0000, 1'b1}};

   cod_top #(.NUM_CH(NCH)) u_dut (.clk_i(clk_i), .rst_n_i(rst_n_i), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .global_output_enable_pin_i(gpin),
      .align_n_i(align_n), .clkout_o(clkout), .clkout_off_o(clkoff),
      .channel_delay_code_o(dly), .cal_start_o(cal_start));
   cod_clk_sink #(.NUM_CH(NCH)) u_sink (.clk_i(clk_i), .clkout_i(clkout), .clear_i(clear),
      .hi_cnt_o(hi), .lo_max_o(lo_max));

   initial begin
      clk_i = 1'b0;
      forever #5 clk_i = ~clk_i;
   end
   always @(posedge clk_i) if (cal_start === 1'b1) cal_seen++;

   task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
      compares++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
      end
   endtask
   // request held until pready is seen, then one idle edge before the next setup
   task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int k;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      k = 0;
      do begin
         @(posedge clk_i);
         k++;
      end while (pready !== 1'b1 && k < 20);
      rd = prdata;
      err = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      chk("pready", k < 20, 1'b1);
      @(posedge clk_i);
   endtask
   task automatic measure(input int w);
      clear <= 1'b1;
      @(posedge clk_i);
      clear <= 1'b0;
      repeat (w + 1) @(posedge clk_i);
   endtask
   task automatic results();
      $display("comparisons %0d mismatches %0d", compares, n_mismatch);
      if (n_mismatch == 0 && compares > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   initial begin
      repeat (60000) @(posedge clk_i);
      n_mismatch++;
      results();
   end

   initial begin
      rst_n_i = 1'b0;
      {psel, penable, pwrite, clear} = 4'h0;
      paddr = 8'h00;
      pwdata = 32'h0;
      gpin = 1'b1;
      align_n = 1'b1;
      repeat (5) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(posedge clk_i);
      chk("off after reset", clkoff, {NCH{1'b1}});
      chk("clk after reset", clkout, '0);
      apb(1'b0, 8'h0c, 32'h0);
      chk("ch3 reset", rd, 32'h0000_0010);
      apb(1'b0, 8'h20, 32'h0);
      chk("global reset", rd, 32'h0000_0021);
      $display("reset test done");
      foreach (rows[i]) begin
         apb(1'b1, rows[i].a, rows[i].d);
         apb(1'b0, rows[i].a, 32'h0);
         chk("reg read", rd, rows[i].e);
         chk("reg err", err, rows[i].err);
      end
      $display("register table done");
      apb(1'b1, 8'h24, 32'h0);
      apb(1'b1, 8'h24, 32'h0);
      repeat (3) @(posedge clk_i);
      chk("cal pulses", cal_seen, 2);
      apb(1'b0, 8'h24, 32'h0);
      chk("cal count", rd, 32'h2);
      for (int c = 0; c < 16; c++) begin
         apb(1'b1, 8'h08, 32'h5000 | c);
         repeat (2) @(posedge clk_i);
         chk("delay code", dly[11:8], c);
      end
      apb(1'b1, 8'h08, 32'h3015);
      repeat (2) @(posedge clk_i);
      chk("no delay code", dly[11:8], 4'h0);
      $display("calibrate and delay done");
      apb(1'b1, 8'h20, 32'h21);
      apb(1'b1, 8'h00, 32'h1000);
      measure(40);
      chk("ch0 on", hi[0], 20);
      chk("ch1 off", clkoff[1], 1'b1);
      gpin <= 1'b0;
      measure(40);
      chk("pin low clk", hi[0], 0);
      chk("pin low off", clkoff[0], 1'b0);
      gpin <= 1'b1;
      apb(1'b1, 8'h20, 32'h20);
      measure(40);
      chk("bit clear clk", hi[0], 0);
      chk("bit clear off", clkoff[0], 1'b1);
      apb(1'b1, 8'h20, 32'h21);
      apb(1'b1, 8'h00, 32'h0);
      repeat (3) @(posedge clk_i);
      chk("ch0 disabled", clkoff[0], 1'b1);
      $display("enable test done");
      apb(1'b1, 8'h00, 32'h1000);
      apb(1'b1, 8'h04, 32'h3010);
      foreach (pd[i]) begin
         apb(1'b1, 8'h20, 32'((pd[i] << 4) | 1));
         repeat (10) @(posedge clk_i);
         measure(1680);
         chk("bypass duty", hi[0], 1680 / pd[i] * (pd[i] / 2));
         chk("divided duty", hi[1], 840);
      end
      $display("duty test done");
      apb(1'b1, 8'h20, 32'h21);
      apb(1'b1, 8'h08, 32'h3020);
      align_n <= 1'b0;
      repeat (20) @(posedge clk_i);
      measure(20);
      chk("held ch1", hi[1], 0);
      chk("held ch2", hi[2], 0);
      chk("bypass runs", hi[0], 10);
      apb(1'b0, 8'h28, 32'h0);
      chk("status held", rd & 32'hf, 32'h6);
      align_n <= 1'b1;
      n = 0;
      while (!(clkout[1] | clkout[2]) && n < 40) begin
         @(posedge clk_i);
         n++;
      end
      chk("same rise", clkout[2:1], 2'b11);
      chk("release delay", n >= 11 && n <= 14, 1'b1);
      repeat (20) @(posedge clk_i);
      align_n <= 1'b0;
      repeat (3) @(posedge clk_i);
      align_n <= 1'b1;
      measure(40);
      chk("short pulse", lo_max[1] >= 8, 1'b1);
      $display("align test done");
      results();
   end
endmodule
